// >>> core/dma_maint_pkg.sv
// Package with control register layout, reset values and shared types for the maintenance control block.
package dma_maint_pkg;
   localparam int CTRL_W = 16;
   localparam int BIT_SYNC = 4;
   localparam int BIT_DONE = 5;
   localparam int BIT_STEP = 6;
   localparam int BIT_BUSOVR = 7;
   localparam int BIT_CHAN = 8;
   localparam int BIT_MAINT = 9;
   localparam int BIT_CMPA = 10;
   localparam int BIT_CMPB = 11;
   localparam int BIT_CCORR = 12;
   localparam int BIT_DEVLCK = 13;
   localparam int BIT_GATLCK = 14;
   localparam int BIT_BLOCK = 15;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] WR_MASK = 16'hFFC0;
   localparam int STATE_W = 8;
   localparam logic [7:0] STATE_RESET = 8'h0F;
   localparam int REQ_N = 16;
   localparam int PULSE_CYC = 1;

   typedef struct packed {
      logic step;
      logic bus_override;
      logic chan_only;
      logic maint;
      logic cmp_a_off;
      logic cmp_b_off;
      logic comp_corr;
      logic dev_lock;
      logic gat_lock;
      logic block_offline;
   } ctrl_t;
endpackage

// >>> core/dma_pulse_gen.sv
// Rising-edge pulse generator used for the halt-driven internal reset.
`timescale 1ns/1ps
module dma_pulse_gen
   import dma_maint_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic level_i,
   output logic pulse_o
);
   logic last_q, last_d, pulse_q, pulse_d;
   always_comb begin
      last_d = level_i;
      pulse_d = level_i & ~last_q;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         last_q <= last_d;
         pulse_q <= pulse_d;
      end
   end
   assign pulse_o = pulse_q;
endmodule

// >>> core/dma_state_ring.sv
// Rotating state register with hold, single step and checker enable.
`timescale 1ns/1ps
module dma_state_ring
   import dma_maint_pkg::*;
#(
   parameter int W = STATE_W
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sync_rst_i,
   input wire logic hold_i,
   input wire logic step_i,
   output logic [W-1:0] state_o,
   output logic check_en_o
);
   logic [W-1:0] st_q, st_d;
   logic chk_q, chk_d;
   always_comb begin
      st_d = st_q;
      chk_d = ~hold_i;
      if (sync_rst_i) begin
         st_d = W'(STATE_RESET);
         chk_d = 1'b0;
      end else if (!hold_i || step_i) begin
         st_d = {st_q[W-2:0], st_q[W-1]};
         chk_d = 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= W'(STATE_RESET);
         chk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         chk_q <= chk_d;
      end
   end
   assign state_o = st_q;
   assign check_en_o = chk_q;
endmodule

// >>> core/dma_maintenance_control.sv
// Maintenance and diagnostic control of the memory transfer unit.
`timescale 1ns/1ps
module dma_maintenance_control
   import dma_maint_pkg::*;
#(
   parameter int REQ_W = REQ_N
)
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic CTRL_LOAD_I,
   input wire logic [15:0] CTRL_WDATA_I,
   input wire logic CHANNEL_SYNC_N_I,
   input wire logic STORE_DONE_N_I,
   input wire logic SINGLE_STEP_CROSSPOINT_I,
   input wire logic HOST_ONLINE_I,
   input wire logic HOST_HALT_I,
   input wire logic ERROR_I,
   input wire logic [REQ_W-1:0] DEVICE_TRANSFER_REQUEST_I,
   input wire logic [REQ_W-1:0] REQ_MASK_I,
   input wire logic CMP_A_EQ_I,
   input wire logic CMP_B_EQ_I,
   input wire logic STORE_REQ_I,
   input wire logic OFFLINE_STORE_REQ_I,
   output logic [15:0] CTRL_RDATA_O,
   output logic STORE_BUS_EN_O,
   output logic STORE_PASS_OFFLINE_O,
   output logic [REQ_W-1:0] REQ_TO_PRIORITY_O,
   output logic ADDR_END_O,
   output logic COMP_CORR_EN_O,
   output logic FORCE_DEV_ERR_O,
   output logic FORCE_GATE_ERR_O,
   output logic HOLD_CLOCK_O,
   output logic CHECK_EN_O,
   output logic CHAN_HOST_ONLY_O,
   output logic INT_RESET_O,
   output logic [STATE_W-1:0] STATE_O
);
   // ==========================================================
   // Control register
   // ==========================================================
   logic [15:0] ctrl_q, ctrl_d;
   ctrl_t c;
   logic int_rst;

   always_comb begin
      ctrl_d = ctrl_q;
      if (int_rst) begin
         ctrl_d = CTRL_RESET;
      end else if (CTRL_LOAD_I) begin
         ctrl_d = CTRL_WDATA_I & WR_MASK;
      end
   end
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always_comb begin
      c.step = ctrl_q[BIT_STEP];
      c.bus_override = ctrl_q[BIT_BUSOVR];
      c.chan_only = ctrl_q[BIT_CHAN];
      c.maint = ctrl_q[BIT_MAINT];
      c.cmp_a_off = ctrl_q[BIT_CMPA];
      c.cmp_b_off = ctrl_q[BIT_CMPB];
      c.comp_corr = ctrl_q[BIT_CCORR];
      c.dev_lock = ctrl_q[BIT_DEVLCK];
      c.gat_lock = ctrl_q[BIT_GATLCK];
      c.block_offline = ctrl_q[BIT_BLOCK];
   end

   // ==========================================================
   // Halt-driven internal reset
   // ==========================================================
   dma_pulse_gen u_halt (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .level_i(HOST_HALT_I),
      .pulse_o(int_rst)
   );

   // ==========================================================
   // State register and hold clock
   // ==========================================================
   logic hold;
   logic [STATE_W-1:0] state;
   logic check_en;
   // Errors and both stop modes share one hold term; a single step advances the ring only in step mode, with no error and channel-only off.
   assign hold = ERROR_I | c.step | c.chan_only;

   dma_state_ring #(.W(STATE_W)) u_ring (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .sync_rst_i(int_rst),
      .hold_i(hold),
      .step_i(SINGLE_STEP_CROSSPOINT_I & c.step & ~c.chan_only & ~ERROR_I),
      .state_o(state),
      .check_en_o(check_en)
   );

   // ==========================================================
   // Registered outputs
   // ==========================================================
   logic [15:0] rd_d, rd_q;
   logic bus_d, bus_q, pass_d, pass_q, end_d, end_q;
   logic [REQ_W-1:0] req_d, req_q;
   logic fde_d, fde_q, fge_d, fge_q, hold_d, hold_q, rst_d, rst_q;
   logic [REQ_W-1:0] req_forced;

   // Each receiver is forced on bit by bit in maintenance; the host mask then decides what reaches priority.
   for (genvar g = 0; g < REQ_W; g++) begin : gen_req
      assign req_forced[g] = (c.maint | DEVICE_TRANSFER_REQUEST_I[g]) & REQ_MASK_I[g];
   end

   always_comb begin
      rd_d = ctrl_q;
      rd_d[BIT_SYNC] = ~CHANNEL_SYNC_N_I;
      rd_d[BIT_DONE] = ~STORE_DONE_N_I;
      bus_d = STORE_REQ_I & (HOST_ONLINE_I | c.bus_override);
      pass_d = OFFLINE_STORE_REQ_I & ~c.block_offline;
      // With the forced receivers, the host mask alone selects the simulated devices.
      req_d = req_forced;
      end_d = (CMP_A_EQ_I & ~c.cmp_a_off) | (CMP_B_EQ_I & ~c.cmp_b_off);
      fde_d = c.maint & c.dev_lock;
      fge_d = c.maint & c.gat_lock;
      hold_d = hold;
      rst_d = int_rst;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rd_q <= 16'h0000;
         bus_q <= 1'b0;
         pass_q <= 1'b0;
         req_q <= '0;
         end_q <= 1'b0;
         fde_q <= 1'b0;
         fge_q <= 1'b0;
         hold_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rd_q <= rd_d;
         bus_q <= bus_d;
         pass_q <= pass_d;
         req_q <= req_d;
         end_q <= end_d;
         fde_q <= fde_d;
         fge_q <= fge_d;
         hold_q <= hold_d;
         rst_q <= rst_d;
      end
   end

   assign CTRL_RDATA_O = rd_q;
   assign STORE_BUS_EN_O = bus_q;
   assign STORE_PASS_OFFLINE_O = pass_q;
   assign REQ_TO_PRIORITY_O = req_q;
   assign ADDR_END_O = end_q;
   assign COMP_CORR_EN_O = ctrl_q[BIT_CCORR];
   assign FORCE_DEV_ERR_O = fde_q;
   assign FORCE_GATE_ERR_O = fge_q;
   assign HOLD_CLOCK_O = hold_q;
   assign CHECK_EN_O = check_en;
   assign CHAN_HOST_ONLY_O = ctrl_q[BIT_CHAN];
   assign INT_RESET_O = rst_q;
   assign STATE_O = state;

   // ==========================================================
   // Assertions
   // ==========================================================
   hold_stops_ring_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (hold && !SINGLE_STEP_CROSSPOINT_I && !int_rst) |=> (state == $past(state)))
      else $error("State moved while held.");
   step_once_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.step && !c.chan_only && !ERROR_I && SINGLE_STEP_CROSSPOINT_I && !int_rst)
      |=> (state == {$past(state[STATE_W-2:0]), $past(state[STATE_W-1])}))
      else $error("Single step did not advance once.");
   offline_bus_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (!HOST_ONLINE_I && !c.bus_override) |=> !STORE_BUS_EN_O)
      else $error("Store bus driven while off line.");
   override_bus_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.bus_override && STORE_REQ_I) |=> STORE_BUS_EN_O)
      else $error("Override did not enable store bus.");
   maint_force_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      c.maint |=> (REQ_TO_PRIORITY_O == $past(REQ_MASK_I)))
      else $error("Maintenance requests not forced.");
   cmp_path_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.cmp_a_off && c.cmp_b_off) |=> !ADDR_END_O)
      else $error("Disabled comparators still report end.");
   block_store_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      c.block_offline |=> !STORE_PASS_OFFLINE_O)
      else $error("Off-line store signal passed.");
   halt_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(HOST_HALT_I) |=> ##1 (INT_RESET_O && ctrl_q == CTRL_RESET))
      else $error("Halt did not reset unit.");
   force_err_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.maint && c.dev_lock) |=> FORCE_DEV_ERR_O)
      else $error("Device error not forced.");
   readback_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      1'b1 |=> (CTRL_RDATA_O[BIT_SYNC] == !$past(CHANNEL_SYNC_N_I)))
      else $error("Sync readback wrong.");

   // ==========================================================
   // Assertions: state ring, hold clock, checker enable and reset pulse
   // ==========================================================
   run_free_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (!hold && !int_rst) |=> (state == {$past(state[STATE_W-2:0]), $past(state[STATE_W-1])}))
      else $error("Free-running ring did not rotate.");
   hold_out_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      c.step |=> HOLD_CLOCK_O)
      else $error("Step mode did not raise hold clock.");
   chan_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.chan_only && !int_rst) |=> (state == $past(state)))
      else $error("Ring moved in channel-only mode.");
   error_freeze_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (ERROR_I && !int_rst) |=> (state == $past(state)))
      else $error("Ring moved during an error.");
   error_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      ERROR_I |=> HOLD_CLOCK_O)
      else $error("Error did not raise hold clock.");
   step_check_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.step && !c.chan_only && !ERROR_I && SINGLE_STEP_CROSSPOINT_I && !int_rst) |=> CHECK_EN_O)
      else $error("Step did not enable the checker.");
   idle_check_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (hold && !SINGLE_STEP_CROSSPOINT_I) |=> !CHECK_EN_O)
      else $error("Checker enabled while held.");
   unit_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      int_rst |=> (ctrl_q == CTRL_RESET && state == STATE_RESET))
      else $error("Internal reset left state behind.");
   halt_pulse_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(HOST_HALT_I) |=> int_rst)
      else $error("Halt did not start the reset pulse.");
   pulse_single_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      int_rst |=> !int_rst)
      else $error("Reset pulse longer than one cycle.");

   // ==========================================================
   // Assertions: control register, forced errors and read-back
   // ==========================================================
   load_mask_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (CTRL_LOAD_I && !int_rst) |=> (ctrl_q == ($past(CTRL_WDATA_I) & WR_MASK)))
      else $error("Load stored the wrong bits.");
   readonly_low_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      1'b1 |=> (CTRL_RDATA_O[BIT_SYNC-1:0] == 4'h0))
      else $error("Unused read-back bits not zero.");
   ctrl_readback_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      1'b1 |=> (CTRL_RDATA_O[CTRL_W-1:BIT_STEP] == $past(ctrl_q[CTRL_W-1:BIT_STEP])))
      else $error("Writable bits read back wrong.");
   readback_done_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      1'b1 |=> (CTRL_RDATA_O[BIT_DONE] == !$past(STORE_DONE_N_I)))
      else $error("Store done readback wrong.");
   corr_load_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (CTRL_LOAD_I && !int_rst) |=> (COMP_CORR_EN_O == $past(CTRL_WDATA_I[BIT_CCORR])))
      else $error("Complement correction enable wrong.");
   chan_load_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (CTRL_LOAD_I && !int_rst) |=> (CHAN_HOST_ONLY_O == $past(CTRL_WDATA_I[BIT_CHAN])))
      else $error("Channel-only output wrong.");
   gate_err_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.maint && c.gat_lock) |=> FORCE_GATE_ERR_O)
      else $error("Gating error not forced.");
   no_force_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !c.maint |=> (!FORCE_DEV_ERR_O && !FORCE_GATE_ERR_O))
      else $error("Error forced outside maintenance.");

   // ==========================================================
   // Assertions: store bus, requests and comparators
   // ==========================================================
   online_bus_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (HOST_ONLINE_I && STORE_REQ_I) |=> STORE_BUS_EN_O)
      else $error("On-line store request not granted.");
   pass_open_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (!c.block_offline && OFFLINE_STORE_REQ_I) |=> STORE_PASS_OFFLINE_O)
      else $error("Unblocked off-line signal dropped.");
   cmp_a_only_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.cmp_b_off && !c.cmp_a_off) |=> (ADDR_END_O == $past(CMP_A_EQ_I)))
      else $error("First comparator path alone wrong.");
   cmp_b_only_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (c.cmp_a_off && !c.cmp_b_off) |=> (ADDR_END_O == $past(CMP_B_EQ_I)))
      else $error("Second comparator path alone wrong.");
   normal_req_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !c.maint |=> (REQ_TO_PRIORITY_O == ($past(DEVICE_TRANSFER_REQUEST_I) & $past(REQ_MASK_I))))
      else $error("Device requests not passed through mask.");
endmodule

// >>> tb/dma_host_model.sv
// Host processor model: loads control, programs the request mask, steps and resets the unit.
`timescale 1ns/1ps
module dma_host_model (
   input wire logic clk_i,
   output logic rst_n_o,
   output logic load_o,
   output logic [15:0] wdata_o,
   output logic step_o,
   output logic [15:0] mask_o
);
   // =====
   // Host actions.
   initial begin
      rst_n_o = 1'b0;
      load_o = 1'b0;
      wdata_o = 16'h0000;
      step_o = 1'b0;
      mask_o = 16'hFFFF;
   end
   task automatic mrf_reset();
      rst_n_o <= 1'b0;
      repeat (16) @(posedge clk_i);
      rst_n_o <= 1'b1;
   endtask
   // Write data is scrambled once the load drops, so a late sample shows up.
   task automatic write_ctrl(input logic [15:0] d);
      @(posedge clk_i);
      load_o <= 1'b1;
      wdata_o <= d;
      @(posedge clk_i);
      load_o <= 1'b0;
      wdata_o <= ~d;
   endtask
   task automatic set_mask(input logic [15:0] m);
      @(posedge clk_i);
      mask_o <= m;
   endtask
   task automatic step_pulse();
      @(posedge clk_i);
      step_o <= 1'b1;
      @(posedge clk_i);
      step_o <= 1'b0;
   endtask
endmodule

// >>> tb/dma_maintenance_control_bench.sv
// Self-checking bench for the maintenance control block.
`timescale 1ns/1ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %s", $time, m); end end
module dma_maintenance_control_bench;
   import dma_maint_pkg::*;
   typedef struct packed {
      logic [15:0] c;
      logic [6:0] in;
      logic [15:0] rq;
      logic [15:0] mk;
      logic en;
      logic ps;
      logic ae;
      logic [15:0] pr;
   } row_t;
   // Inputs are on, store request, off-line request, comparator A, B, sync_n, done_n.
   localparam row_t ROWS [7] = '{
      {16'h003F, 7'b0111001, 16'h0005, 16'hFFFF, 3'b011, 16'h0005},
      {16'h0080, 7'b0111110, 16'h0000, 16'hFFFF, 3'b111, 16'h0000},
      {16'h8200, 7'b1111111, 16'h0000, 16'h0A0A, 3'b101, 16'h0A0A},
      {16'h0400, 7'b1001011, 16'h1234, 16'h00FF, 3'b000, 16'h0034},
      {16'h0800, 7'b1110111, 16'hFFFF, 16'h0F0F, 3'b110, 16'h0F0F},
      {16'h7E00, 7'b1111111, 16'h0000, 16'h8001, 3'b110, 16'h8001},
      {16'h6100, 7'b1111111, 16'h00F0, 16'hFFFF, 3'b111, 16'h00F0}};
   logic clk = 1'b0;
   logic rst_n, load, step, bus_en, pass, aend, corr, dev_err, gat_err, hold, check, chan, int_rst;
   logic [8:0] ctl = 9'h003;
   logic [15:0] req = 16'h0000;
   logic [15:0] wdata, mask, rdata, prio;
   logic [7:0] state, s;
   row_t r;
   logic [4:0] mode;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int n_check = 0;
   int n_irst = 0;
   int b;
   initial forever #12.5 clk = ~clk;
   // =====
   // Units under test.
   dma_host_model dma_host_model_inst (.clk_i(clk), .rst_n_o(rst_n), .load_o(load), .wdata_o(wdata),
      .step_o(step), .mask_o(mask));
   dma_maintenance_control dma_maintenance_control_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
      .CTRL_LOAD_I(load), .CTRL_WDATA_I(wdata), .CHANNEL_SYNC_N_I(ctl[1]), .STORE_DONE_N_I(ctl[0]),
      .SINGLE_STEP_CROSSPOINT_I(step), .HOST_ONLINE_I(ctl[6]), .HOST_HALT_I(ctl[8]), .ERROR_I(ctl[7]),
      .DEVICE_TRANSFER_REQUEST_I(req), .REQ_MASK_I(mask), .CMP_A_EQ_I(ctl[3]), .CMP_B_EQ_I(ctl[2]),
      .STORE_REQ_I(ctl[5]), .OFFLINE_STORE_REQ_I(ctl[4]), .CTRL_RDATA_O(rdata), .STORE_BUS_EN_O(bus_en),
      .STORE_PASS_OFFLINE_O(pass), .REQ_TO_PRIORITY_O(prio), .ADDR_END_O(aend), .COMP_CORR_EN_O(corr),
      .FORCE_DEV_ERR_O(dev_err), .FORCE_GATE_ERR_O(gat_err), .HOLD_CLOCK_O(hold), .CHECK_EN_O(check),
      .CHAN_HOST_ONLY_O(chan), .INT_RESET_O(int_rst), .STATE_O(state));
   always @(negedge clk) begin
      n_check += (check === 1'b1);
      n_irst += (int_rst === 1'b1);
   end
   // The whole run needs well under a thousand cycles; the ceiling leaves room.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // =====
   // Tests.
   initial begin
      dma_host_model_inst.mrf_reset();
      @(negedge clk);
      `CHK(state, STATE_RESET, "reset state")
      `CHK({rdata, int_rst, hold}, 18'h00000, "reset outputs")
      $display("test reset done");
      foreach (ROWS[i]) begin
         r = ROWS[i];
         @(posedge clk);
         ctl[6:0] <= r.in;
         req <= r.rq;
         dma_host_model_inst.set_mask(r.mk);
         dma_host_model_inst.write_ctrl(r.c);
         repeat (3) @(posedge clk);
         @(negedge clk);
         mode = {r.c[12], r.c[8], r.c[9] & r.c[13], r.c[9] & r.c[14], r.c[6] | r.c[8]};
         `CHK(rdata, {r.c[15:6], ~r.in[0], ~r.in[1], 4'h0}, "read back")
         `CHK(bus_en, r.en, "bus enable")
         `CHK(pass, r.ps, "offline pass")
         `CHK(prio, r.pr, "priority requests")
         `CHK(aend, r.ae, "address end")
         `CHK({corr, chan, dev_err, gat_err, hold}, mode, "mode bits")
      end
      $display("test rows done");
      dma_host_model_inst.write_ctrl(16'h0040);
      repeat (3) @(negedge clk);
      s = state;
      repeat (4) @(negedge clk);
      `CHK(state, s, "held ring")
      repeat (2) begin
         b = n_check;
         dma_host_model_inst.step_pulse();
         repeat (4) @(negedge clk);
         s = {s[6:0], s[7]};
         `CHK(state, s, "single step")
         `CHK(n_check - b, 1, "check enable")
      end
      $display("test step done");
      dma_host_model_inst.write_ctrl(16'h0000);
      ctl[7] <= 1'b1;
      repeat (3) @(negedge clk);
      s = state;
      repeat (3) @(negedge clk);
      `CHK({hold, state}, {1'b1, s}, "error hold")
      @(posedge clk);
      ctl[7] <= 1'b0;
      $display("test error done");
      dma_host_model_inst.write_ctrl(16'hFFC0);
      b = n_irst;
      @(posedge clk);
      ctl[8] <= 1'b1;
      repeat (6) @(negedge clk);
      `CHK(n_irst - b, 1, "halt pulse")
      `CHK(rdata, 16'h0000, "halt clears")
      $display("test halt done");
      dma_host_model_inst.write_ctrl(16'hFFC0);
      ctl[8] <= 1'b0;
      dma_host_model_inst.mrf_reset();
      @(negedge clk);
      `CHK(state, STATE_RESET, "mid-run reset state")
      `CHK({rdata, int_rst, hold}, 18'h00000, "mid-run reset outputs")
      repeat (2) @(negedge clk);
      `CHK(rdata, 16'h0000, "mid-run reset clears control")
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule
